/* rtl/co2_params.svh */
`ifndef CO2_PARAMS_SVH
`define CO2_PARAMS_SVH

`define CLK_KHZ       125000
`define PERIOD_MS     500
`define PERIOD_CYC    (`PERIOD_MS * `CLK_KHZ)
`define READY_US      16500
`define READY_CYC     (`READY_US * `CLK_KHZ / 1000)
`define SETUP_MS      14
`define SETUP_CYC     (`SETUP_MS * `CLK_KHZ)
`define FIRST_MIN_MS  800
`define FIRST_MIN_CYC (`FIRST_MIN_MS * `CLK_KHZ)
`define BAUD_RATE     9600
`define BAUD_CYC      (`CLK_KHZ * 1000 / `BAUD_RATE)
`define STRAP_WAIT    3'h4
`define FULL_SCALE    16'h07D0
`define FRESH_RST     16'h0190
`define FILT_RST      8'h10
`define FILT_MIN      8'h01
`define CONC_W        16
`define FRAC_W        8

`endif

/* rtl/co2_pkg.sv */
`include "co2_params.svh"

package co2_pkg;

  typedef enum logic [2:0] {
    OP_NOP        = 3'h0,
    OP_SET_FILT   = 3'h1,
    OP_SET_KNOWN  = 3'h2,
    OP_ZERO_KNOWN = 3'h3,
    OP_ZERO_N2    = 3'h4,
    OP_SET_FRESH  = 3'h5,
    OP_ZERO_FRESH = 3'h6,
    OP_FINE_ADJ   = 3'h7
  } op_t;

  // Gray along strap, warm-up, pulse, setup, open
  typedef enum logic [2:0] {
    ST_STRAP = 3'h0,
    ST_WARM  = 3'h1,
    ST_PULSE = 3'h3,
    ST_SETUP = 3'h2,
    ST_OPEN  = 3'h6
  } phase_t;

  typedef struct packed {
    logic                 valid;
    op_t                  op;
    logic [`CONC_W-1:0]   arg;
    logic [`CONC_W-1:0]   arg2;
  } cmd_t;

  typedef struct packed {
    logic [`CONC_W-1:0] filt;
    logic [`CONC_W-1:0] raw;
  } meas_t;

endpackage

/* rtl/pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module pin_sync (
  input  wire logic clk_i,    // Clock
  input  wire logic rstn_i,   // Async reset, active low
  input  wire logic ce_i,     // Clock enable
  input  wire logic pin_i,    // Asynchronous pin
  output logic      level_o   // Filtered level
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // Idle high: a floating pin is pulled up
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_reg  <= 1'b1;
      s2_reg  <= 1'b1;
      s3_reg  <= 1'b1;
      level_o <= 1'b1;
    end else if (ce_i) begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_o <= s3_reg;
      end
    end
  end

endmodule // pin_sync

`default_nettype wire

/* rtl/meas_filter.sv */
`timescale 1ns/100ps
`default_nettype none

module meas_filter #(
  parameter int CW = `CONC_W,
  parameter int FW = `FRAC_W
) (
  input  wire logic          clk_i,     // Clock
  input  wire logic          rstn_i,    // Async reset, active low
  input  wire logic          ce_i,      // Clock enable
  input  wire logic          step_i,    // New sample strobe
  input  wire logic [CW-1:0] raw_i,     // Unfiltered sample
  input  wire logic [7:0]    setting_i, // Filter setting 1..255
  output logic      [CW-1:0] filt_o     // Filtered value
);

  // Shift approximates 1/N so no divider is needed
  function automatic logic [2:0] shift_of(input logic [7:0] n);
    logic [2:0] k;
    k = 3'h0;
    for (int i = 1; i < 8; i++) begin
      if (n[i]) k = 3'(i);
    end
    return k;
  endfunction

  logic [CW+FW-1:0]        acc_reg;
  wire  [2:0]              k = shift_of(setting_i);
  wire  signed [CW+FW:0]   diff = $signed({1'b0, raw_i, {FW{1'b0}}}) - $signed({1'b0, acc_reg});
  wire  signed [CW+FW:0]   delta = diff >>> k;
  wire  [CW+FW:0]          sum = {1'b0, acc_reg} + delta;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc_reg <= '0;
    end else if (ce_i && step_i) begin
      acc_reg <= sum[CW+FW-1:0];
    end
  end

  assign filt_o = acc_reg[CW+FW-1:FW];

endmodule // meas_filter

`default_nettype wire

/* rtl/co2_measurement_cycle_control.sv */
`timescale 1ns/100ps
`default_nettype none

module co2_measurement_cycle_control
  import co2_pkg::*;
#(
  parameter int unsigned      PERIOD_CYC    = `PERIOD_CYC,
  parameter int unsigned      READY_CYC     = `READY_CYC,
  parameter int unsigned      SETUP_CYC     = `SETUP_CYC,
  parameter int unsigned      FIRST_MIN_CYC = `FIRST_MIN_CYC,
  parameter int unsigned      BAUD_CYC      = `BAUD_CYC,
  parameter logic [15:0]      FULL_SCALE    = `FULL_SCALE
) (
  input  wire logic           clk_i,        // 125 MHz clock
  input  wire logic           rstn_i,       // Async reset, active low
  input  wire logic           ce_i,         // Clock enable, freezes all
  input  wire logic           if_sel_n_i,   // Interface select pin
  input  wire logic [15:0]    sample_i,     // Uncorrected front-end reading
  input  wire cmd_t           cmd_i,        // Command from serial decoder
  input  wire logic           rd_req_i,     // Data read request
  output logic                ready_o,      // Data-ready pin
  output logic                i2c_mode_o,   // 1 = I2C, 0 = UART
  output logic                mode_valid_o, // Mode strap latched
  output logic                avail_o,      // Control interface open
  output logic                baud_tick_o,  // UART bit-rate strobe
  output meas_t               meas_o,       // Latest data for host
  output logic                rd_valid_o,   // Read answered
  output logic                rd_rej_o,     // Read refused
  output logic                cmd_ack_o,    // Command done
  output logic                cmd_rej_o,    // Command refused
  output logic [7:0]          filt_set_o,   // Filter setting
  output logic signed [17:0]  zero_off_o    // Zero-point offset
);

  localparam int PW = $clog2(PERIOD_CYC + 1);
  localparam int HW = $clog2((READY_CYC > SETUP_CYC ? READY_CYC : SETUP_CYC) + 1);
  localparam int MW = $clog2(FIRST_MIN_CYC + 1);
  localparam int BW = $clog2(BAUD_CYC + 1);

  function automatic logic [15:0] clamp_conc(input logic signed [17:0] v);
    logic [15:0] r;
    if (v < 18'sh0) begin
      r = 16'h0000;
    end else if (v > $signed({2'b00, FULL_SCALE})) begin
      r = FULL_SCALE;
    end else begin
      r = v[15:0];
    end
    return r;
  endfunction

  // State
  phase_t              st_reg;
  phase_t              st_next;
  logic [2:0]          strap_cnt_reg;
  logic [PW-1:0]       per_cnt_reg;
  logic [HW-1:0]       ph_cnt_reg;
  logic [MW-1:0]       min_cnt_reg;
  logic                min_done_reg;
  logic [7:0]          meas_cnt_reg;
  logic [BW-1:0]       baud_cnt_reg;
  logic                first_seen_reg;
  logic [15:0]         known_reg;
  logic [15:0]         fresh_reg;
  logic [15:0]         raw_reg;
  logic                step_reg;
  logic                pub_reg;
  logic                pin_lvl;
  logic [15:0]         filt_w;

  pin_sync u_sync (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .ce_i    (ce_i),
    .pin_i   (if_sel_n_i),
    .level_o (pin_lvl)
  );

  meas_filter u_filt (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .ce_i      (ce_i),
    .step_i    (step_reg),
    .raw_i     (raw_reg),
    .setting_i (filt_set_o),
    .filt_o    (filt_w)
  );

  // Decoding
  wire running   = (st_reg != ST_STRAP);
  wire strap_now = (st_reg == ST_STRAP) && (strap_cnt_reg == `STRAP_WAIT);
  wire meas_tick = running && (per_cnt_reg == PW'(PERIOD_CYC - 1));
  wire [7:0] meas_cnt_inc = (meas_cnt_reg == 8'hFF) ? 8'hFF : meas_cnt_reg + 8'h01;
  // Warm-up gates only the first pulse; a later filter change must not stall the cycle
  wire warm_ok   = first_seen_reg || (min_done_reg && (meas_cnt_inc >= filt_set_o));
  wire fire      = meas_tick && warm_ok;
  wire pulse_end = (st_reg == ST_PULSE) && (ph_cnt_reg == HW'(READY_CYC - 1));
  wire setup_end = (st_reg == ST_SETUP) && (ph_cnt_reg == HW'(SETUP_CYC - 1));
  wire open      = (st_reg == ST_OPEN);

  wire signed [17:0] corr_sum = $signed({2'b00, sample_i}) + zero_off_o;
  wire [15:0]        corr     = clamp_conc(corr_sum);

  // Zero targets; known, N2 and fresh relative to the uncorrected reading, fine adjust relative to the current offset
  wire signed [17:0] samp_s   = $signed({2'b00, sample_i});
  wire signed [17:0] off_known = $signed({2'b00, known_reg}) - samp_s;
  wire signed [17:0] off_n2    = 18'sh0 - samp_s;
  wire signed [17:0] off_fresh = $signed({2'b00, fresh_reg}) - samp_s;
  wire signed [17:0] off_fine  = zero_off_o
                               + ($signed({2'b00, cmd_i.arg}) - $signed({2'b00, cmd_i.arg2}));

  // Command decode; only taken while the interface is open
  wire cmd_go    = cmd_i.valid && open;
  wire bad_filt  = (cmd_i.op == OP_SET_FILT) && (cmd_i.arg[15:8] != 8'h00 || cmd_i.arg[7:0] < `FILT_MIN);
  wire bad_fresh = (cmd_i.op == OP_SET_FRESH) && (cmd_i.arg > FULL_SCALE);
  wire bad_fine  = (cmd_i.op == OP_FINE_ADJ) && i2c_mode_o;
  wire cmd_ok    = cmd_go && !bad_filt && !bad_fresh && !bad_fine;
  wire cmd_bad   = cmd_i.valid && !cmd_ok;
  wire rd_ok     = rd_req_i && open && first_seen_reg;

  // Phase sequencer
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_STRAP: begin
        if (strap_now) st_next = ST_WARM;
      end
      ST_WARM: begin
        if (fire) st_next = ST_PULSE;
      end
      ST_PULSE: begin
        if (pulse_end) st_next = ST_SETUP;
      end
      ST_SETUP: begin
        if (fire) st_next = ST_PULSE;
        else if (setup_end) st_next = ST_OPEN;
      end
      ST_OPEN: begin
        if (fire) st_next = ST_PULSE;
      end
      default: begin
        st_next = ST_STRAP;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg <= ST_STRAP;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  // Strap capture, once per power cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      strap_cnt_reg <= 3'h0;
      i2c_mode_o    <= 1'b0;
      mode_valid_o  <= 1'b0;
    end else if (ce_i && !running) begin
      if (strap_now) begin
        i2c_mode_o   <= ~pin_lvl;
        mode_valid_o <= 1'b1;
      end else begin
        strap_cnt_reg <= strap_cnt_reg + 3'h1;
      end
    end
  end
  // Nothing rewrites the mode after strap capture

  // Period, phase and warm-up timers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      per_cnt_reg <= '0;
    end else if (ce_i && running) begin
      per_cnt_reg <= meas_tick ? '0 : per_cnt_reg + PW'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ph_cnt_reg <= '0;
    end else if (ce_i) begin
      if (st_next != st_reg || fire) ph_cnt_reg <= '0;
      else ph_cnt_reg <= ph_cnt_reg + HW'(1);
    end
  end

  // Warm-up ends at 0.8 s and after filter-setting measurements
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      min_cnt_reg  <= '0;
      min_done_reg <= 1'b0;
      meas_cnt_reg <= 8'h00;
    end else if (ce_i) begin
      if (!min_done_reg) begin
        min_cnt_reg  <= min_cnt_reg + MW'(1);
        min_done_reg <= (min_cnt_reg == MW'(FIRST_MIN_CYC - 1));
      end
      if (meas_tick) meas_cnt_reg <= meas_cnt_inc;
    end
  end

  // Measurement capture and published data
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      raw_reg  <= 16'h0000;
      step_reg <= 1'b0;
      pub_reg  <= 1'b0;
    end else if (ce_i) begin
      step_reg <= meas_tick;
      pub_reg  <= step_reg;
      if (meas_tick) raw_reg <= corr;
    end
  end

  // Published one cycle after the filter steps, so both match
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meas_o <= '0;
    end else if (ce_i && pub_reg) begin
      meas_o.raw  <= raw_reg;
      meas_o.filt <= filt_w;
    end
  end

  // Data-ready and availability
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ready_o        <= 1'b0;
      avail_o        <= 1'b0;
      first_seen_reg <= 1'b0;
    end else if (ce_i) begin
      ready_o <= (st_next == ST_PULSE);
      avail_o <= (st_next == ST_OPEN);
      if (st_reg == ST_PULSE) first_seen_reg <= 1'b1;
    end
  end

  // Read answers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_valid_o <= 1'b0;
      rd_rej_o   <= 1'b0;
    end else if (ce_i) begin
      rd_valid_o <= rd_ok;
      rd_rej_o   <= rd_req_i && !rd_ok;
    end
  end

  // Configuration and calibration
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      filt_set_o <= `FILT_RST;
      known_reg  <= 16'h0000;
      fresh_reg  <= `FRESH_RST;
      zero_off_o <= 18'sh0;
    end else if (ce_i && cmd_ok) begin
      case (cmd_i.op)
        OP_SET_FILT:   filt_set_o <= cmd_i.arg[7:0];
        OP_SET_KNOWN:  known_reg  <= cmd_i.arg;
        OP_ZERO_KNOWN: zero_off_o <= off_known;
        OP_ZERO_N2:    zero_off_o <= off_n2;
        OP_SET_FRESH:  fresh_reg  <= cmd_i.arg;
        OP_ZERO_FRESH: zero_off_o <= off_fresh;
        OP_FINE_ADJ:   zero_off_o <= off_fine;
        default:       known_reg  <= known_reg;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmd_ack_o <= 1'b0;
      cmd_rej_o <= 1'b0;
    end else if (ce_i) begin
      cmd_ack_o <= cmd_ok;
      cmd_rej_o <= cmd_bad;
    end
  end

  // Fixed bit-rate strobe, UART mode only; no rate register exists
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      baud_cnt_reg <= '0;
      baud_tick_o  <= 1'b0;
    end else if (ce_i) begin
      if (mode_valid_o && !i2c_mode_o) begin
        baud_tick_o  <= (baud_cnt_reg == BW'(BAUD_CYC - 1));
        baud_cnt_reg <= (baud_cnt_reg == BW'(BAUD_CYC - 1)) ? '0 : baud_cnt_reg + BW'(1);
      end else begin
        baud_tick_o  <= 1'b0;
        baud_cnt_reg <= '0;
      end
    end
  end

endmodule // co2_measurement_cycle_control

`default_nettype wire

/* testbench/co2_cycle_sva.sv */
`timescale 1ns/100ps
`default_nettype none

module co2_cycle_sva
  import co2_pkg::*;
#(
  parameter int unsigned READY_CYC     = 20,
  parameter int unsigned SETUP_CYC     = 16,
  parameter int unsigned FIRST_MIN_CYC = 500,
  parameter int unsigned BAUD_CYC      = 10
) (
  input wire logic  clk_i,        // Clock
  input wire logic  rstn_i,       // Reset, active low
  input wire logic  ce_i,         // Clock enable
  input wire cmd_t  cmd_i,        // Command
  input wire logic  rd_req_i,     // Read request
  input wire logic  ready_o,      // Data-ready pin
  input wire logic  i2c_mode_o,   // Latched mode
  input wire logic  mode_valid_o, // Mode latched
  input wire logic  avail_o,      // Interface open
  input wire logic  baud_tick_o,  // Bit-rate strobe
  input wire meas_t meas_o,       // Output data
  input wire logic  rd_valid_o,   // Read answered
  input wire logic  rd_rej_o,     // Read refused
  input wire logic  cmd_ack_o,    // Command done
  input wire logic  cmd_rej_o     // Command refused
);
  localparam int BD    = BAUD_CYC;
  localparam int SU_HI = SETUP_CYC + 2;

  int unsigned hi_cnt;
  int unsigned lo_cnt;
  int unsigned up_cnt;
  logic        seen_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hi_cnt <= '0;
      lo_cnt <= '0;
      up_cnt <= '0;
      seen_q <= 1'b0;
    end else if (ce_i) begin
      hi_cnt <= ready_o ? hi_cnt + 1 : '0;
      lo_cnt <= ready_o ? '0 : lo_cnt + 1;
      up_cnt <= up_cnt + 1;
      seen_q <= seen_q | ready_o;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_cmd_rej;
    cmd_rej_o && !cmd_ack_o;
  endsequence
  sequence s_rd_ans;
    rd_valid_o && !rd_rej_o;
  endsequence

  a_ready_avail_excl: assert property (!(ready_o && avail_o))
    else $error("ready and avail high together");
  a_ready_width: assert property ($fell(ready_o) |-> hi_cnt == READY_CYC)
    else $error("ready pulse width wrong");
  a_setup_gap: assert property ($rose(avail_o) |-> lo_cnt >= SETUP_CYC)
    else $error("interface opened too soon");
  a_setup_bound: assert property ($fell(ready_o) |-> ##[1:SU_HI] avail_o)
    else $error("interface did not open");
  a_cmd_closed: assert property (ce_i && cmd_i.valid && !avail_o |=> s_cmd_rej)
    else $error("command taken while closed");
  a_rd_closed: assert property (ce_i && rd_req_i && !avail_o |=> rd_rej_o && !rd_valid_o)
    else $error("read answered while closed");
  a_rd_open: assert property (ce_i && rd_req_i && avail_o |=> s_rd_ans)
    else $error("read not answered");
  a_mode_fixed: assert property (mode_valid_o |=> $stable(i2c_mode_o) && mode_valid_o)
    else $error("mode changed after latch");
  a_meas_period: assert property ($changed(meas_o) && seen_q |-> ready_o)
    else $error("data changed outside measurement");
  a_first_late: assert property ($rose(ready_o) && !seen_q |-> up_cnt >= FIRST_MIN_CYC)
    else $error("first ready too early");
  a_baud_uart: assert property (baud_tick_o |-> !i2c_mode_o ##BD baud_tick_o)
    else $error("bit-rate strobe wrong");
endmodule // co2_cycle_sva

bind co2_measurement_cycle_control co2_cycle_sva #(
  .READY_CYC(READY_CYC), .SETUP_CYC(SETUP_CYC), .FIRST_MIN_CYC(FIRST_MIN_CYC), .BAUD_CYC(BAUD_CYC)
) co2_cycle_sva_inst (
  .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .cmd_i(cmd_i), .rd_req_i(rd_req_i), .ready_o(ready_o),
  .i2c_mode_o(i2c_mode_o), .mode_valid_o(mode_valid_o), .avail_o(avail_o), .baud_tick_o(baud_tick_o),
  .meas_o(meas_o), .rd_valid_o(rd_valid_o), .rd_rej_o(rd_rej_o), .cmd_ack_o(cmd_ack_o), .cmd_rej_o(cmd_rej_o)
);

`default_nettype wire

/* testbench/host_model.sv */
`timescale 1ns/100ps
`default_nettype none

module host_model
  import co2_pkg::*;
(
  input  wire logic clk_i,   // Clock
  input  wire logic rstn_i,  // Reset, active low
  input  wire logic avail_i, // Device interface open
  input  wire logic go_i,    // Start one request
  input  wire logic force_i, // Send without waiting
  input  wire logic rd_i,    // Request is a read
  input  wire cmd_t req_i,   // Command to send
  output var  cmd_t cmd_o,   // Command strobe to device
  output var  logic rd_o     // Read strobe to device
);
  logic pend;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pend  <= 1'b0;
      cmd_o <= '0;
      rd_o  <= 1'b0;
    end else begin
      cmd_o.valid <= 1'b0;
      // Idle argument keeps moving so a stale word is never mistaken
      cmd_o.arg   <= ~cmd_o.arg;
      rd_o        <= 1'b0;
      if (go_i) begin
        pend <= 1'b1;
      end else if (pend && (avail_i || force_i)) begin
        pend <= 1'b0;
        rd_o <= rd_i;
        if (!rd_i) cmd_o <= req_i;
      end
    end
  end
endmodule // host_model

`default_nettype wire

/* testbench/co2_measurement_cycle_control_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, exp, seen) begin check_count++; if ((seen) !== (exp)) begin mismatches++; \
  $display("Error %s expected %0h seen %0h", nm, exp, seen); end end

module co2_measurement_cycle_control_tb_top
  import co2_pkg::*;
;
  localparam int unsigned PER = 400, RDY = 20, SU = 16, FMIN = 500;
  typedef struct {op_t op; logic [15:0] a; logic [15:0] b; logic ack; logic chk; logic signed [17:0] off;} step_t;

  logic              clk_i, rstn_i, ce_i, if_sel_n_i, rd_req_i, go, hrd, hfrc, got;
  logic              ready_o, i2c_mode_o, mode_valid_o, avail_o, baud_tick_o;
  logic              rd_valid_o, rd_rej_o, cmd_ack_o, cmd_rej_o;
  logic [15:0]       sample_i;
  logic [7:0]        filt_set_o;
  logic signed [17:0] zero_off_o;
  cmd_t              cmd_i, hc;
  meas_t             meas_o;
  int                mismatches = 0, check_count = 0, cyc = 0, t_rst, t0, tr;

  co2_measurement_cycle_control #(.PERIOD_CYC(PER), .READY_CYC(RDY), .SETUP_CYC(SU), .FIRST_MIN_CYC(FMIN),
    .BAUD_CYC(10), .FULL_SCALE(16'h07D0)) co2_measurement_cycle_control_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .if_sel_n_i(if_sel_n_i), .sample_i(sample_i), .cmd_i(cmd_i),
    .rd_req_i(rd_req_i), .ready_o(ready_o), .i2c_mode_o(i2c_mode_o), .mode_valid_o(mode_valid_o),
    .avail_o(avail_o), .baud_tick_o(baud_tick_o), .meas_o(meas_o), .rd_valid_o(rd_valid_o),
    .rd_rej_o(rd_rej_o), .cmd_ack_o(cmd_ack_o), .cmd_rej_o(cmd_rej_o), .filt_set_o(filt_set_o),
    .zero_off_o(zero_off_o));
  host_model host_model_inst (.clk_i(clk_i), .rstn_i(rstn_i), .avail_i(avail_o), .go_i(go), .force_i(hfrc),
    .rd_i(hrd), .req_i(hc), .cmd_o(cmd_i), .rd_o(rd_req_i));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc <= cyc + 1;

  task automatic test_done();
    $display("Checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic do_reset(input logic sel);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    if_sel_n_i <= sel;
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_rst = cyc;
    repeat (8) @(posedge clk_i);
    #1;
  endtask

  task automatic wait_lvl(input logic use_av, input logic lvl, input int lim);
    int n;
    n = 0;
    while (n < lim && ((use_av ? avail_o : ready_o) !== lvl)) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    `CHK("wait bound", 1'b1, n < lim)
  endtask

  // Handshake runs through the host model; a forced request ignores the open window
  task automatic req(input op_t op, input logic [15:0] a, input logic [15:0] b, input logic rd, input logic frc);
    int n;
    @(posedge clk_i);
    hc <= '{1'b1, op, a, b};
    hrd <= rd;
    hfrc <= frc;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    #1;
    n = 0;
    while (n < 10000 && (cmd_ack_o | cmd_rej_o | rd_valid_o | rd_rej_o) !== 1'b1) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    got = cmd_ack_o | rd_valid_o;
  endtask

  task automatic t_boot();
    int n;
    `CHK("mode latched", 1'b1, mode_valid_o)
    n = 0;
    while (baud_tick_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (baud_tick_o !== 1'b1 && n < 50);
    `CHK("baud spacing", 10, n)
    `CHK("uart mode", 1'b0, i2c_mode_o)
    `CHK("ready low", 1'b0, ready_o)
    @(posedge clk_i);
    if_sel_n_i <= 1'b0;
    req(OP_SET_FILT, 16'h0001, 16'h0000, 1'b0, 1'b1);
    `CHK("early cmd", 1'b0, got)
    req(OP_NOP, 16'h0000, 16'h0000, 1'b1, 1'b1);
    `CHK("early read", 1'b0, got)
    `CHK("mode held", 1'b0, i2c_mode_o)
    `CHK("filter kept", 8'h10, filt_set_o)
  endtask

  task automatic t_cycle();
    wait_lvl(1'b0, 1'b1, 20000);
    `CHK("first ready", 1'b1, (cyc - t_rst) >= FMIN)
    tr = cyc;
    wait_lvl(1'b0, 1'b0, 100);
    `CHK("ready width", RDY, cyc - tr)
    t0 = cyc;
    wait_lvl(1'b1, 1'b1, 100);
    `CHK("setup gap", 1'b1, (cyc - t0) >= SU)
    wait_lvl(1'b0, 1'b1, 1000);
    `CHK("period", PER, cyc - tr)
    req(OP_SET_FILT, 16'h0001, 16'h0000, 1'b0, 1'b1);
    `CHK("cmd in pulse", 1'b0, got)
    req(OP_NOP, 16'h0000, 16'h0000, 1'b1, 1'b1);
    `CHK("read in pulse", 1'b0, got)
  endtask

  // Known level is written before its zero command
  task automatic t_cmds();
    step_t tbl [10] = '{
      '{OP_SET_FILT, 16'h0000, 16'h0000, 1'b0, 1'b0, 18'sh00000},
      '{OP_SET_FILT, 16'h00FF, 16'h0000, 1'b1, 1'b0, 18'sh00000},
      '{OP_SET_FRESH, 16'h07D1, 16'h0000, 1'b0, 1'b0, 18'sh00000},
      '{OP_SET_FRESH, 16'h07D0, 16'h0000, 1'b1, 1'b0, 18'sh00000},
      '{OP_ZERO_FRESH, 16'h0000, 16'h0000, 1'b1, 1'b1, 18'sh006D0},
      '{OP_SET_KNOWN, 16'h0300, 16'h0000, 1'b1, 1'b0, 18'sh00000},
      '{OP_ZERO_KNOWN, 16'h0000, 16'h0000, 1'b1, 1'b1, 18'sh00200},
      '{OP_FINE_ADJ, 16'h0010, 16'h0008, 1'b1, 1'b1, 18'sh00208},
      '{OP_ZERO_N2, 16'h0000, 16'h0000, 1'b1, 1'b1, -18'sh00100},
      '{OP_SET_FILT, 16'h0001, 16'h0000, 1'b1, 1'b0, 18'sh00000}};
    @(posedge clk_i);
    sample_i <= 16'h0100;
    foreach (tbl[i]) begin
      req(tbl[i].op, tbl[i].a, tbl[i].b, 1'b0, 1'b0);
      `CHK("cmd answer", tbl[i].ack, got)
      if (tbl[i].chk) `CHK("zero offset", tbl[i].off, zero_off_o)
    end
    `CHK("filter set", 8'h01, filt_set_o)
  endtask

  task automatic t_meas();
    @(posedge clk_i);
    sample_i <= 16'h0164;
    wait_lvl(1'b0, 1'b1, 1000);
    req(OP_NOP, 16'h0000, 16'h0000, 1'b1, 1'b0);
    `CHK("read answered", 1'b1, got)
    `CHK("raw value", 16'h0064, meas_o.raw)
    `CHK("unfiltered", 16'h0064, meas_o.filt)
  endtask

  task automatic t_i2c();
    do_reset(1'b0);
    `CHK("i2c mode", 1'b1, i2c_mode_o)
    `CHK("no baud in i2c", 1'b0, baud_tick_o)
    req(OP_FINE_ADJ, 16'h0010, 16'h0008, 1'b0, 1'b0);
    `CHK("fine adj i2c", 1'b0, got)
    req(OP_ZERO_FRESH, 16'h0000, 16'h0000, 1'b0, 1'b0);
    `CHK("fresh ack", 1'b1, got)
    `CHK("fresh default", 18'sh0002C, zero_off_o)
  endtask

  initial begin
    rstn_i = 1'b0;
    ce_i = 1'b1;
    if_sel_n_i = 1'b1;
    sample_i = 16'h0100;
    go = 1'b0;
    hrd = 1'b0;
    hfrc = 1'b0;
    hc = '0;
    do_reset(1'b1);
    t_boot();
    t_cycle();
    t_cmds();
    t_meas();
    t_i2c();
    test_done();
  end

  // Both warm-ups plus a few periods stay well inside this span
  initial begin
    #(60000 * 8);
    mismatches++;
    test_done();
  end
endmodule // co2_measurement_cycle_control_tb_top

`default_nettype wire
